// file: pkg/wdt_defs.svh
// Constants of the overclock watchdog: register fields, reset values, times.
// Included by the package and design files; holds definitions only.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_CLK_MHZ 200
`define WDT_PULSE_MS 20
`define WDT_PULSE_CYC (`WDT_PULSE_MS * 1000 * `WDT_CLK_MHZ)
`define WDT_TICK_MS 250
`define WDT_TICK_CYC (`WDT_TICK_MS * 1000 * `WDT_CLK_MHZ)
`define WDT_SCALE_LONG_TICKS 4'hC
`define WDT_SCALE_SHORT_TICKS 4'h1
`define WDT_TIMER_RST 3'h0
`define WDT_SCALE_RST 1'h1
`define WDT_RMODE_RST 1'h0
`define WDT_RSRC_RST 1'h0
`define WDT_AUTO_RST 1'h1
`define WDT_N_W 9
`define WDT_M_W 7
`define WDT_O_W 4
`endif

// file: pkg/wdt_pkg.sv
// Types shared by the watchdog design files.
// Assumes wdt_defs.svh is on the include path.
`include "wdt_defs.svh"
package wdt_pkg;
  typedef logic [`WDT_N_W-1:0] n_val_t;
  typedef logic [`WDT_M_W-1:0] m_val_t;
  typedef logic [`WDT_O_W-1:0] o_val_t;
  typedef enum logic [1:0] {
    REC_HW,
    REC_AUTO,
    REC_MANUAL,
    REC_NONE
  } rec_mode_e;
  typedef enum logic [1:0] {
    WD_IDLE,
    WD_COUNT,
    WD_SPENT
  } wd_state_e;
endpackage

// file: design/sync2.sv
// Two flip-flop synchroniser for a single pin level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module sync2 (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out.
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s0;
    logic s1;
  } st_s;
  st_s st_q;
  st_s st_d;
  // The first stage feeds only the second.
  always_comb begin
    st_d.s0 = d;
    st_d.s1 = st_q.s0;
  end
  // Both stages reset high, the idle level of the active-low pins watched here.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{s0: 1'b1, s1: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s1;
endmodule // sync2

// file: design/pulse_timer.sv
// Fixed-length pulse generator for the system reset output.
// Assumes start is a one-cycle pulse on clk.
`timescale 1ns/100ps
`include "wdt_defs.svh"
module pulse_timer #(
  parameter int unsigned LEN = `WDT_PULSE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic start,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic run;
    logic fin;
  } st_s;
  st_s st_q;
  st_s st_d;
  // A start while running is ignored so the pulse keeps its length.
  always_comb begin
    st_d = st_q;
    st_d.fin = 1'b0;
    if (!st_q.run) begin
      if (start) begin
        st_d.run = 1'b1;
        st_d.cnt = LEN - 1;
      end
    end else if (st_q.cnt == 32'h0) begin
      st_d.run = 1'b0;
      st_d.fin = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt - 32'h1;
    end
  end
  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign busy = st_q.run;
  assign done = st_q.fin;
endmodule // pulse_timer

// file: design/overclock_watchdog_reset.sv
// Watchdog timer and system reset pulse logic for an overclocking clock generator.
// Assumes the management bus slave decodes writes into the strobes and fields below,
// and that clk is the device clock derived from the reference.
// The reset pin needs an external pull-up; it is released while the strap disables it.
//
// Behaviour
// [RULE_01] Timeout drives one 20 ms reset pulse.
// [RULE_02] Enabled watchdog counts timer value times scale.
// [RULE_03] Expiry while enabled asserts reset, sets alarm.
// [RULE_04] Reset pin used only if strap low.
// [RULE_05] Timer or scale write restarts countdown; the code restarts only when a value changes.
// [RULE_06] After pulse, idle until rewrite or re-enable; the code restarts only on a changed timer or scale value or an enable rise.
// [RULE_07] Enable resets zero; rising edge reloads countdown.
// [RULE_08] Timer field three bits, resets 000, test.
// [RULE_09] Alarm set on expiry, software clears it.
// [RULE_10] Scale resets 1; selects 250 ms, 3 s.
// [RULE_11] Reset mode zero recovers, one only resets.
// [RULE_12] Recovery source zero selects hardware settings.
// [RULE_13] Autorecovery resets one; hardware writes recovery N.
// [RULE_14] Nine-bit recovery N register, hardware or software.
// [RULE_15] Hardware recovery restores power-up M, N, O.
// [RULE_16] Autorecovery latches M, N at enable.
// [RULE_17] Manual recovery: software N, hidden latched M.
// [RULE_18] No recovery leaves M and N unchanged.
// [RULE_19] Software reset request emits equal pulse.
// [RULE_20] Software reset request clears itself.
// [RULE_21] Host clears enable before expiry.
// [RULE_22] SRC programmable mode has no recovery.
// [RULE_23] Frequency-select mode recovers hardware settings only.
// [RULE_24] Prescaler from clock gives tick time base.
// [RULE_25] Reset output low only during pulse.
`timescale 1ns/100ps
`include "wdt_defs.svh"
module overclock_watchdog_reset #(
  parameter int unsigned TICK_CYC = `WDT_TICK_CYC,
  parameter int unsigned PULSE_CYC = `WDT_PULSE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Boot pins.
  input wire logic reset_pin_strap,
  input wire logic power_good_n,
  // Register write strobes from the management bus, one cycle each.
  input wire logic wr_ctrl,
  input wire logic watchdog_enable_wr,
  input wire logic [2:0] timer_value_wr,
  input wire logic time_scale_wr,
  input wire logic reset_mode_wr,
  input wire logic recovery_src_wr,
  input wire logic autorecovery_wr,
  input wire logic alarm_clear,
  input wire logic software_reset_request_wr,
  input wire logic write_done,
  input wire logic wr_recovery_n,
  input wire wdt_pkg::n_val_t recovery_n_wr,
  // Current PLL operating mode.
  input wire logic cpu_prog_mode,
  input wire logic cpu_freq_select_bits_mode,
  input wire logic src_prog_mode,
  input wire wdt_pkg::n_val_t cur_n,
  input wire wdt_pkg::m_val_t cur_m,
  input wire wdt_pkg::o_val_t cur_o,
  input wire wdt_pkg::n_val_t hw_n,
  input wire wdt_pkg::m_val_t hw_m,
  input wire wdt_pkg::o_val_t hw_o,
  // Register read-back.
  output logic watchdog_enable,
  output logic [2:0] timer_value,
  output logic time_scale,
  output logic reset_mode,
  output logic recovery_src,
  output logic autorecovery,
  output logic alarm,
  output logic software_reset_request,
  output wdt_pkg::n_val_t recovery_n_value,
  // Frequency restore to the CPU PLL.
  output logic restore_load,
  output wdt_pkg::n_val_t restore_n,
  output wdt_pkg::m_val_t restore_m,
  output wdt_pkg::o_val_t restore_o,
  output logic restore_o_valid,
  // System reset pin.
  output logic system_reset_out_n,
  output logic system_reset_oe
);
  import wdt_pkg::*;

  typedef struct packed {
    // Control register fields.
    logic en;
    logic [2:0] tval;
    logic scale;
    logic rmode;
    logic rsrc;
    logic autorec;
    logic alarm;
    logic swreq;
    logic swpend;
    // Recovery latches and the boot-time hardware copy.
    n_val_t rec_n;
    m_val_t rec_m;
    n_val_t hw_n;
    m_val_t hw_m;
    o_val_t hw_o;
    // Strap decision, caught once after power good.
    logic strap_ok;
    logic strap_taken;
    // Countdown: prescaler, units per step, steps left.
    wd_state_e state;
    logic [31:0] pre;
    logic [3:0] sub;
    logic [2:0] left;
    // Registered restore request for the CPU PLL.
    logic rload;
    n_val_t rn;
    m_val_t rm;
    o_val_t ro;
    logic rov;
  } st_s;

  st_s st_q;
  st_s st_d;
  // Synchronised pins, the pulse handshake and the countdown events.
  logic pg_n_s;
  logic strap_s;
  logic pulse_busy;
  logic pulse_start;
  logic expire;
  logic reload;
  rec_mode_e rec_sel;

  // Boot pins pass two flip-flops before use.
  sync2 u_pg_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(power_good_n),
    .q(pg_n_s)
  );
  sync2 u_strap_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(reset_pin_strap),
    .q(strap_s)
  );

  // Shared reset pulse timer for watchdog and software requests.
  pulse_timer #(
    .LEN(PULSE_CYC) // RULE_01
  ) u_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .start(pulse_start),
    .busy(pulse_busy),
    .done()
  );

  // Recovery mode from reset mode, source and autorecovery bits.
  always_comb begin
    if (st_q.rmode) begin
      rec_sel = REC_NONE; // RULE_11
    end else if (!st_q.rsrc) begin
      rec_sel = REC_HW; // RULE_12
    end else if (st_q.autorec) begin
      rec_sel = REC_AUTO;
    end else begin
      rec_sel = REC_MANUAL;
    end
  end

  // Reload when a timer or scale field changes or enable rises.
  // Rewriting the same timer and scale values leaves a running count alone.
  assign reload = (wr_ctrl && (timer_value_wr != st_q.tval || time_scale_wr != st_q.scale)) // RULE_05
    || (wr_ctrl && watchdog_enable_wr && !st_q.en); // RULE_07

  // Expiry is the last tick of the last unit while still enabled.
  // An enable cleared by a write in the expiry cycle itself comes too late.
  assign expire = (st_q.state == WD_COUNT) && st_q.en && !reload && st_q.pre == 32'h0
    && st_q.sub == 4'h1 && st_q.left == 3'h1; // RULE_03

  // Software pulse starts at the end of the write, and only if no pulse is running in that cycle.
  // Watchdog and software pulses share one timer and one pin.
  assign pulse_start = st_q.strap_ok && !pulse_busy && (expire || (st_q.swpend && write_done)); // RULE_19

  // Next-state logic.
  always_comb begin
    st_d = st_q;
    st_d.rload = 1'b0;

    // Strap is caught once, on power good asserting low.
    // Both pins pass the same two stages, so they are read in the same cycle;
    // the strap is static by then and later changes of it are ignored.
    if (!st_q.strap_taken && !pg_n_s) begin
      st_d.strap_taken = 1'b1;
      st_d.strap_ok = !strap_s; // RULE_04
      st_d.hw_n = hw_n; // RULE_15
      st_d.hw_m = hw_m;
      st_d.hw_o = hw_o;
    end

    // Control register writes.
    // Every field of the control byte but the software request, which only sets, is taken at once from one write.
    if (wr_ctrl) begin
      st_d.en = watchdog_enable_wr;
      st_d.tval = timer_value_wr; // RULE_08
      st_d.scale = time_scale_wr; // RULE_10
      st_d.rmode = reset_mode_wr;
      st_d.rsrc = recovery_src_wr;
      st_d.autorec = autorecovery_wr;
      if (software_reset_request_wr) begin
        st_d.swreq = 1'b1;
        st_d.swpend = 1'b1;
      end
      // Enable rising latches present M and N for later restore.
      // M is always latched; N only when autorecovery is written on with the enable.
      if (watchdog_enable_wr && !st_q.en) begin
        st_d.rec_m = cur_m; // RULE_17
        if (autorecovery_wr) begin
          st_d.rec_n = cur_n; // RULE_16
        end
      end
    end

    // Software may write recovery N only with autorecovery off.
    // In auto mode the register belongs to the hardware latch above.
    if (wr_recovery_n && !st_q.autorec) begin
      st_d.rec_n = recovery_n_wr; // RULE_13
    end

    // Software clears the alarm; a same-cycle expiry wins.
    // The set below comes later in this process, so it overrides the clear.
    if (alarm_clear) begin
      st_d.alarm = 1'b0;
    end

    // Request bit clears itself once its pulse starts.
    // A request waiting behind a running pulse stays pending until the next write ends.
    if (pulse_start && st_q.swpend && !expire) begin
      st_d.swreq = 1'b0; // RULE_20
      st_d.swpend = 1'b0;
    end
    // Without the strap there is no pin to pulse, so the request is dropped.
    if (st_q.swpend && write_done && !st_q.strap_ok) begin
      st_d.swreq = 1'b0;
      st_d.swpend = 1'b0;
    end

    // Countdown state machine on a prescaled tick.
    // Timer code 000 is the reserved test mode and never counts.
    unique case (st_q.state)
      WD_IDLE, WD_SPENT: begin
        if (reload && st_d.en && st_d.tval != 3'h0) begin
          st_d.state = WD_COUNT; // RULE_06
        end
      end
      WD_COUNT: begin
        if (!st_d.en || st_d.tval == 3'h0) begin
          st_d.state = WD_IDLE;
        end else if (expire) begin
          st_d.state = WD_SPENT; // RULE_06
        end
      end
    endcase

    // A reload beats ticking, so a changed timer or scale value or an enable rise always restarts the full count.
    if (reload) begin
      st_d.pre = TICK_CYC - 1; // RULE_24
      st_d.sub = st_d.scale ? `WDT_SCALE_LONG_TICKS : `WDT_SCALE_SHORT_TICKS; // RULE_10
      st_d.left = st_d.tval; // RULE_02
    end else if (st_q.state == WD_COUNT) begin
      if (st_q.pre != 32'h0) begin
        st_d.pre = st_q.pre - 32'h1; // RULE_24
      end else begin
        // Prescaler wrapped: one 250 ms unit has passed.
        st_d.pre = TICK_CYC - 1;
        // Each step is twelve units in the 3 s scale and one in the 250 ms scale.
        if (st_q.sub != 4'h1) begin
          st_d.sub = st_q.sub - 4'h1;
        end else begin
          st_d.sub = st_q.scale ? `WDT_SCALE_LONG_TICKS : `WDT_SCALE_SHORT_TICKS;
          st_d.left = st_q.left - 3'h1; // RULE_02
        end
      end
    end

    // Expiry sets the alarm and selects what to restore.
    // Only the CPU PLL has a recovery path; SRC programmable mode alone restores nothing.
    if (expire) begin
      st_d.alarm = 1'b1; // RULE_09
      st_d.rov = 1'b0;
      st_d.rload = !src_prog_mode || cpu_prog_mode || cpu_freq_select_bits_mode; // RULE_22
      // Frequency-select mode must use the hardware set, the only one carrying O.
      if (cpu_freq_select_bits_mode || rec_sel == REC_HW) begin
        st_d.rn = st_q.hw_n; // RULE_23
        st_d.rm = st_q.hw_m;
        st_d.ro = st_q.hw_o; // RULE_15
        st_d.rov = 1'b1;
        st_d.rload = st_d.rload && !st_q.rmode;
      end else if (rec_sel == REC_AUTO || rec_sel == REC_MANUAL) begin
        // Auto and manual restore N and M; O is passed through unchanged.
        st_d.rn = st_q.rec_n; // RULE_14
        st_d.rm = st_q.rec_m; // RULE_16
        st_d.ro = cur_o;
      end else begin
        st_d.rload = 1'b0; // RULE_18
      end
      if (!cpu_prog_mode && !cpu_freq_select_bits_mode) begin
        st_d.rload = 1'b0;
      end
    end
  end

  // State register; all fields take constants under reset.
  // Fields not named below, the alarm among them, reset to zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.en <= 1'b0; // RULE_07
      st_q.tval <= `WDT_TIMER_RST; // RULE_08
      st_q.scale <= `WDT_SCALE_RST;
      st_q.rmode <= `WDT_RMODE_RST; // RULE_11
      st_q.rsrc <= `WDT_RSRC_RST; // RULE_12
      st_q.autorec <= `WDT_AUTO_RST; // RULE_13
      st_q.state <= WD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Register read-back.
  assign watchdog_enable = st_q.en;
  assign timer_value = st_q.tval;
  assign time_scale = st_q.scale;
  assign reset_mode = st_q.rmode;
  assign recovery_src = st_q.rsrc;
  assign autorecovery = st_q.autorec;
  assign alarm = st_q.alarm;
  assign software_reset_request = st_q.swreq;
  assign recovery_n_value = st_q.rec_n;
  // Restore outputs, load strobe one cycle after expiry.
  assign restore_load = st_q.rload;
  assign restore_n = st_q.rn;
  assign restore_m = st_q.rm;
  assign restore_o = st_q.ro;
  assign restore_o_valid = st_q.rov;
  // Pin is low only during a pulse and driven only when strapped on.
  assign system_reset_out_n = !pulse_busy; // RULE_25
  assign system_reset_oe = st_q.strap_ok; // RULE_04
endmodule // overclock_watchdog_reset

// file: verification/wdt_props.sv
// Port checker for the watchdog reset block, bound into its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module wdt_props #(
  parameter int unsigned PULSE_CYC = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register writes.
  input wire logic wr_ctrl,
  input wire logic watchdog_enable_wr,
  input wire logic [2:0] timer_value_wr,
  input wire logic write_done,
  input wire logic wr_recovery_n,
  input wire wdt_pkg::n_val_t recovery_n_wr,
  // PLL mode.
  input wire logic cpu_prog_mode,
  input wire logic cpu_freq_select_bits_mode,
  input wire wdt_pkg::n_val_t hw_n,
  // Watched outputs.
  input wire logic watchdog_enable,
  input wire logic [2:0] timer_value,
  input wire logic reset_mode,
  input wire logic autorecovery,
  input wire logic alarm,
  input wire logic software_reset_request,
  input wire wdt_pkg::n_val_t recovery_n_value,
  input wire logic restore_load,
  input wire wdt_pkg::n_val_t restore_n,
  input wire logic system_reset_out_n,
  input wire logic system_reset_oe
);
  import wdt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int unsigned low_q;
  // Counts the cycles the reset output has been low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_q <= 0;
    else low_q <= system_reset_out_n ? 0 : low_q + 1;
  end
  a_pulse_len: assert property ($rose(system_reset_out_n) |-> low_q == PULSE_CYC)
    else $error("reset pulse length wrong");
  a_alarm_reset: assert property ($rose(alarm) && system_reset_oe |-> $fell(system_reset_out_n))
    else $error("alarm without reset pulse");
  a_restore_cause: assert property (restore_load |-> $rose(alarm) && !reset_mode && (cpu_prog_mode || cpu_freq_select_bits_mode))
    else $error("restore without cause");
  a_freq_select_bits_hw: assert property (restore_load && cpu_freq_select_bits_mode |-> restore_n == hw_n)
    else $error("select mode restored non-hardware N");
  a_sw_pulse: assert property (software_reset_request && write_done && system_reset_out_n && system_reset_oe
    |=> !system_reset_out_n && !software_reset_request)
    else $error("software reset not issued");
  a_ctrl_rdbk: assert property (wr_ctrl |=> watchdog_enable == $past(watchdog_enable_wr)
    && timer_value == $past(timer_value_wr))
    else $error("control read-back wrong");
  a_recn_lock: assert property (wr_recovery_n && autorecovery && !wr_ctrl |=> $stable(recovery_n_value))
    else $error("recovery N written in auto mode");
  a_recn_user: assert property (wr_recovery_n && !autorecovery && !wr_ctrl
    |=> recovery_n_value == $past(recovery_n_wr))
    else $error("recovery N write lost");
  a_out_idle: assert property (!system_reset_oe |-> system_reset_out_n)
    else $error("reset driven while unused");
  c_pulse: cover property ($fell(system_reset_out_n));
  c_restore: cover property (restore_load);
  c_user_n: cover property (wr_recovery_n && !autorecovery);
endmodule // wdt_props
bind overclock_watchdog_reset wdt_props #(.PULSE_CYC(PULSE_CYC)) props (.*);

// file: verification/sys_reset_sink.sv
// Board-side system reset input that measures reset pulses.
// Assumes a pull-up holds the line high when the pin is not driven.
`timescale 1ns/100ps
module sys_reset_sink (
  // Clock.
  input wire logic clk,
  // Reset pin.
  input wire logic pin_n,
  input wire logic pin_oe,
  // Pulse statistics.
  output int pulses,
  output int last_len
);
  int run;
  logic line_n;
  // The pull-up wins whenever the device releases the pin.
  assign line_n = pin_oe ? pin_n : 1'b1;
  initial begin
    pulses = 0;
    last_len = 0;
    run = 0;
  end
  // Counts low cycles and records each finished pulse.
  always @(posedge clk) begin
    if (line_n !== 1'b1) run <= run + 1;
    else if (run != 0) begin
      pulses <= pulses + 1;
      last_len <= run;
      run <= 0;
    end
  end
endmodule // sys_reset_sink

// file: verification/testbench.sv
// Self-checking bench for the watchdog reset block.
// Assumes the board model and the checker are compiled before it.
`timescale 1ns/100ps
module testbench;
  import wdt_pkg::*;
  localparam int PL = 20;
  logic clk, rst_n, reset_pin_strap, power_good_n, wr_ctrl, watchdog_enable_wr, time_scale_wr;
  logic reset_mode_wr, recovery_src_wr, autorecovery_wr, alarm_clear, software_reset_request_wr;
  logic write_done, wr_recovery_n, cpu_prog_mode, cpu_freq_select_bits_mode, src_prog_mode, watchdog_enable;
  logic time_scale, reset_mode, recovery_src, autorecovery, alarm, software_reset_request;
  logic restore_load, restore_o_valid, system_reset_out_n, system_reset_oe;
  logic [2:0] timer_value_wr, timer_value, md;
  n_val_t recovery_n_wr, cur_n, hw_n, recovery_n_value, restore_n;
  m_val_t cur_m, hw_m, restore_m;
  o_val_t cur_o, hw_o, restore_o;
  int err_total = 0, cmp_count = 0, cyc = 0, pulses, last_len, rl_cnt = 0, n, ep = 0, erl = 0;
  logic [15:0] rl_nm;
  logic [4:0] rl_o;
  logic [15:0] ex [4] = '{16'h6430, 16'h91C5, 16'h52C5, 16'h0000};
  logic [2:0] mds [4] = '{3'h1, 3'h3, 3'h2, 3'h5};

  overclock_watchdog_reset #(.TICK_CYC(10), .PULSE_CYC(PL)) dut (
    .clk(clk), .rst_n(rst_n), .reset_pin_strap(reset_pin_strap), .power_good_n(power_good_n),
    .wr_ctrl(wr_ctrl), .watchdog_enable_wr(watchdog_enable_wr), .timer_value_wr(timer_value_wr),
    .time_scale_wr(time_scale_wr), .reset_mode_wr(reset_mode_wr), .recovery_src_wr(recovery_src_wr),
    .autorecovery_wr(autorecovery_wr), .alarm_clear(alarm_clear),
    .software_reset_request_wr(software_reset_request_wr), .write_done(write_done),
    .wr_recovery_n(wr_recovery_n), .recovery_n_wr(recovery_n_wr), .cpu_prog_mode(cpu_prog_mode),
    .cpu_freq_select_bits_mode(cpu_freq_select_bits_mode), .src_prog_mode(src_prog_mode), .cur_n(cur_n), .cur_m(cur_m), .cur_o(cur_o),
    .hw_n(hw_n), .hw_m(hw_m), .hw_o(hw_o), .watchdog_enable(watchdog_enable), .timer_value(timer_value),
    .time_scale(time_scale), .reset_mode(reset_mode), .recovery_src(recovery_src), .autorecovery(autorecovery),
    .alarm(alarm), .software_reset_request(software_reset_request), .recovery_n_value(recovery_n_value),
    .restore_load(restore_load), .restore_n(restore_n), .restore_m(restore_m), .restore_o(restore_o),
    .restore_o_valid(restore_o_valid), .system_reset_out_n(system_reset_out_n), .system_reset_oe(system_reset_oe)
  );
  sys_reset_sink sink (.clk(clk), .pin_n(system_reset_out_n), .pin_oe(system_reset_oe), .pulses(pulses),
    .last_len(last_len));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      close_out();
    end
  end
  // Captures every frequency restore.
  always @(posedge clk) begin
    if (restore_load === 1'b1) begin
      rl_cnt <= rl_cnt + 1;
      rl_nm <= {restore_n, restore_m};
      rl_o <= {restore_o_valid, restore_o};
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One control byte write followed by the end of the bus transaction.
  task automatic wc(input logic en, input logic [2:0] tv, input logic sc, input logic sw);
    @(posedge clk);
    {watchdog_enable_wr, timer_value_wr, time_scale_wr} <= {en, tv, sc};
    {reset_mode_wr, recovery_src_wr, autorecovery_wr, software_reset_request_wr} <= {md, sw};
    wr_ctrl <= 1'b1;
    @(posedge clk);
    wr_ctrl <= 1'b0;
    write_done <= 1'b1;
    @(posedge clk);
    write_done <= 1'b0;
  endtask

  task automatic wrn(input logic [15:0] exp);
    @(posedge clk);
    recovery_n_wr <= 9'h0A5;
    wr_recovery_n <= 1'b1;
    @(posedge clk);
    wr_recovery_n <= 1'b0;
    @(negedge clk);
    chk("recovery n", 16'(recovery_n_value), exp);
  endtask

  // Enables a countdown and measures the time to alarm, pulse and clear.
  task automatic run_wd(input logic [2:0] tv, input logic sc, input int exp);
    wc(1'h1, tv, sc, 1'h0);
    n = 1;
    do begin
      @(negedge clk);
      n++;
    end while (alarm !== 1'b1 && n < 400);
    chk("expiry", 16'(n >= exp && n <= exp + 3), 16'h1);
    repeat (PL + 5) @(negedge clk);
    ep++;
    chk("pulses", 16'(pulses), 16'(ep));
    chk("pulse len", 16'(last_len), 16'(PL));
    @(posedge clk);
    alarm_clear <= 1'b1;
    @(posedge clk);
    alarm_clear <= 1'b0;
    @(negedge clk);
    chk("alarm clear", 16'(alarm), 16'h0);
  endtask

  initial begin
    {rst_n, reset_pin_strap, wr_ctrl, watchdog_enable_wr, timer_value_wr, time_scale_wr, reset_mode_wr} = '0;
    {recovery_src_wr, autorecovery_wr, alarm_clear, software_reset_request_wr, write_done, wr_recovery_n} = '0;
    {recovery_n_wr, cpu_freq_select_bits_mode, src_prog_mode, cur_n, cur_m} = '0;
    {power_good_n, cpu_prog_mode, hw_n, hw_m, hw_o, cur_o, md} = {2'h3, 9'h0C8, 7'h30, 4'h3, 4'h9, 3'h1};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    power_good_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk("reset regs", 16'({watchdog_enable, timer_value, time_scale, reset_mode, recovery_src, autorecovery,
      alarm, software_reset_request, system_reset_out_n}), 16'h049);
    chk("oe", 16'(system_reset_oe), 16'h1);
    wc(1'h1, 3'h0, 1'h0, 1'h0);
    repeat (60) @(negedge clk);
    chk("test mode", 16'(alarm), 16'h0);
    wc(1'h0, 3'h2, 1'h0, 1'h0);
    wc(1'h1, 3'h2, 1'h0, 1'h0);
    repeat (10) @(negedge clk);
    wc(1'h0, 3'h2, 1'h0, 1'h0);
    repeat (40) @(negedge clk);
    chk("cleared in time", 16'(alarm), 16'h0);
    wc(1'h1, 3'h2, 1'h0, 1'h0);
    repeat (12) @(negedge clk);
    run_wd(3'h3, 1'h0, 30);
    repeat (150) @(negedge clk);
    chk("spent", 16'(alarm), 16'h0);
    run_wd(3'h1, 1'h1, 120);
    wc(1'h0, 3'h1, 1'h0, 1'h0);
    run_wd(3'h1, 1'h0, 10);
    chk("hw restores", 16'(rl_cnt), 16'h3);
    erl = 3;
    for (int i = 0; i < 4; i++) begin
      md = mds[i];
      cur_n <= 9'h123;
      cur_m <= 7'h45;
      cpu_freq_select_bits_mode <= (i == 0);
      wc(1'h0, 3'h1, 1'h0, 1'h0);
      if (i == 2) wrn(16'h00A5);
      fork
        run_wd(3'h1, 1'h0, 10);
        begin
          repeat (4) @(posedge clk);
          cur_n <= 9'h1FE;
          cur_m <= 7'h7E;
        end
      join
      if (i != 3) erl++;
      chk("restores", 16'(rl_cnt), 16'(erl));
      if (i != 3) chk("restore nm", rl_nm, ex[i]);
      if (i != 3) chk("restore o", 16'(i == 0 ? rl_o : {rl_o[4], 4'h0}), i == 0 ? 16'h13 : 16'h00);
      if (i == 1) wrn(16'h0123);
    end
    md = 3'h1;
    cpu_prog_mode <= 1'b0;
    src_prog_mode <= 1'b1;
    wc(1'h0, 3'h1, 1'h0, 1'h0);
    run_wd(3'h1, 1'h0, 10);
    chk("src no restore", 16'(rl_cnt), 16'(erl));
    wc(1'h0, 3'h1, 1'h0, 1'h1);
    @(negedge clk);
    chk("sw start", 16'({software_reset_request, system_reset_out_n}), 16'h0);
    repeat (PL + 5) @(negedge clk);
    ep++;
    chk("sw pulses", 16'(pulses), 16'(ep));
    chk("sw len", 16'(last_len), 16'(PL));
    @(posedge clk);
    rst_n <= 1'b0;
    reset_pin_strap <= 1'b1;
    power_good_n <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    power_good_n <= 1'b0;
    repeat (5) @(negedge clk);
    wc(1'h0, 3'h1, 1'h0, 1'h1);
    repeat (30) @(negedge clk);
    chk("strap off", 16'({system_reset_oe, 8'(pulses)}), 16'(ep));
    close_out();
  end
endmodule // testbench
